// ---- core/ulc_params.svh ----
// register offsets, field positions and timing constants of the serial port
`ifndef ULC_PARAMS_SVH
`define ULC_PARAMS_SVH
`define ULC_OFF_DATA      3'h0
`define ULC_OFF_IEN       3'h1
`define ULC_OFF_IID       3'h2
`define ULC_OFF_LFC       3'h3
`define ULC_OFF_MCR       3'h4
`define ULC_OFF_LSR       3'h5
`define ULC_OFF_MSR       3'h6
`define ULC_OFF_SCR       3'h7
`define ULC_LFC_DLAB      7
`define ULC_LFC_SIL       6
`define ULC_LFC_FIXP      5
`define ULC_LFC_EVEN      4
`define ULC_LFC_PEN       3
`define ULC_LFC_STOP      2
`define ULC_IEN_RX        0
`define ULC_IEN_TX        1
`define ULC_IEN_LS        2
`define ULC_IEN_MS        3
`define ULC_MCR_OUT2      3
`define ULC_MCR_LOOP      4
`define ULC_DIV_RESET     16'h0001
`define ULC_OVS_LAST      4'hF
`define ULC_OVS_HALF      4'h7
`define ULC_IID_NONE      8'h01
`define ULC_IID_LS        8'h06
`define ULC_IID_RX        8'h04
`define ULC_IID_TX        8'h02
`define ULC_IID_MS        8'h00
`endif

// ---- core/ulc_pkg.sv ----
// types shared by the serial port design files
package ulc_pkg;
    typedef enum logic [2:0] {
        ULC_IDLE,
        ULC_START,
        ULC_DATA,
        ULC_PAR,
        ULC_STOP
    } ulc_ph_t;
endpackage

// ---- core/ulc_rx.sv ----
// serial receiver: character framing, parity and stop checking
`timescale 1ns/1ns
`include "ulc_params.svh"
module ulc_rx (
    clk_sys,
    sys_rst,
    tick16,
    serialIn,
    wordLen,
    parityEn,
    parityFix,
    parityEven,
    rxData,
    rxDone,
    rxParityErr,
    rxStopErr,
    rxBreak
);
    input  wire logic       clk_sys;
    input  wire logic       sys_rst;
    input  wire logic       tick16;
    input  wire logic       serialIn;
    input  wire logic [1:0] wordLen;
    input  wire logic       parityEn;
    input  wire logic       parityFix;
    input  wire logic       parityEven;
    output logic      [7:0] rxData;
    output logic            rxDone;
    output logic            rxParityErr;
    output logic            rxStopErr;
    output logic            rxBreak;

    ulc_pkg::ulc_ph_t phase_q;
    logic [3:0] ovs_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic       par_q;
    logic       zero_q;

    wire        midBit  = tick16 && (ovs_q == `ULC_OVS_HALF);
    wire        lastBit = (bit_q == {1'b1, wordLen});
    // expected parity: fixed value, or xor of data bits against even/odd select
    wire        expPar  = parityFix ? ~parityEven : (par_q ^ ~parityEven);
    // right-aligned word, lsb arrived first
    wire  [7:0] alignd  = shift_q >> (2'd3 - wordLen);

    // receiver phase machine; samples mid bit, one stop checked
    always_ff @(posedge clk_sys) begin
        rxDone <= 1'b0;
        if (sys_rst) begin
            phase_q     <= ulc_pkg::ULC_IDLE;
            ovs_q       <= 4'h0;
            bit_q       <= 3'h0;
            shift_q     <= 8'h00;
            par_q       <= 1'b0;
            zero_q      <= 1'b1;
            rxData      <= 8'h00;
            rxParityErr <= 1'b0;
            rxStopErr   <= 1'b0;
            rxBreak     <= 1'b0;
        end else if (tick16) begin
            ovs_q <= ovs_q + 4'h1;
            case (phase_q)
                ulc_pkg::ULC_IDLE: begin
                    ovs_q <= 4'h0;
                    if (!serialIn) begin
                        phase_q <= ulc_pkg::ULC_START;
                        ovs_q   <= 4'h1;
                    end
                end
                ulc_pkg::ULC_START: begin
                    if (midBit) begin
                        // false start filtered: line back high at mid bit
                        phase_q <= serialIn ? ulc_pkg::ULC_IDLE : ulc_pkg::ULC_DATA;
                        bit_q   <= 3'h0;
                        par_q   <= 1'b0;
                        zero_q  <= 1'b1;
                    end
                end
                ulc_pkg::ULC_DATA: begin
                    if (midBit) begin
                        shift_q <= {serialIn, shift_q[7:1]};
                        par_q   <= par_q ^ serialIn;
                        zero_q  <= zero_q & ~serialIn;
                        bit_q   <= bit_q + 3'h1;
                        if (lastBit) begin
                            phase_q <= parityEn ? ulc_pkg::ULC_PAR : ulc_pkg::ULC_STOP;
                        end
                    end
                end
                ulc_pkg::ULC_PAR: begin
                    if (midBit) begin
                        rxParityErr <= (serialIn != expPar);
                        zero_q      <= zero_q & ~serialIn;
                        phase_q     <= ulc_pkg::ULC_STOP;
                    end
                end
                ulc_pkg::ULC_STOP: begin
                    if (midBit) begin
                        rxData    <= alignd;
                        rxStopErr <= ~serialIn;
                        rxBreak   <= zero_q & ~serialIn;
                        rxDone    <= 1'b1;
                        phase_q   <= ulc_pkg::ULC_IDLE;
                        if (!parityEn) begin
                            rxParityErr <= 1'b0;
                        end
                    end
                end
                default: phase_q <= ulc_pkg::ULC_IDLE;
            endcase
        end
    end
endmodule

// ---- core/ulc_uart.sv ----
// serial port top: register window, baud generator, transmitter, interrupts
`timescale 1ns/1ns
`include "ulc_params.svh"
// Function
// - divisor latch select banks offsets zero, one
// - latch clear: data buffers and interrupt enable
// - force silence drives infrared output low
// - fixed parity with even select sends 0
// - fixed parity with odd select sends 1
// - even select gives even ones count
// - parity ignored unless parity enabled
// - parity sits between data and stop
// - extra stop clear gives one stop
// - five bit words get one-and-half stops
// - longer words get two stop bits
// - word length bits pick five to eight
// - least significant data bit goes first
// - fifo indicators and timeout read zero
// - divisor 1..65535 makes 16x tick
// - start, data, parity, stops in order
module ulc_uart (
    clk_sys,
    sys_rst,
    regAddr,
    regWrData,
    regWr,
    regRd,
    regRdData,
    serialIn,
    serial_out,
    infrared_tx_out,
    ctsIn_n,
    dsrIn_n,
    riIn_n,
    dcdIn_n,
    rtsOut_n,
    dtrOut_n,
    irq
);
    input  wire logic       clk_sys;
    input  wire logic       sys_rst;
    input  wire logic [2:0] regAddr;
    input  wire logic [7:0] regWrData;
    input  wire logic       regWr;
    input  wire logic       regRd;
    output logic      [7:0] regRdData;
    input  wire logic       serialIn;
    output logic            serial_out;
    output logic            infrared_tx_out;
    input  wire logic       ctsIn_n;
    input  wire logic       dsrIn_n;
    input  wire logic       riIn_n;
    input  wire logic       dcdIn_n;
    output logic            rtsOut_n;
    output logic            dtrOut_n;
    output logic            irq;

    // ======================================================================
    // registers and pin synchronisers
    logic [7:0]  lfc_q;
    logic [7:0]  ien_q;
    logic [4:0]  mcr_q;
    logic [7:0]  scr_q;
    logic [15:0] div_q;
    logic [7:0]  rbr_q;
    logic [7:0]  thr_q;
    logic        thrFull_q;
    logic        rdr_q;
    logic        oer_q;
    logic        per_q;
    logic        ser_q;
    logic        brk_q;
    logic [3:0]  msDelta_q;
    logic [3:0]  msPrev_q;
    logic [4:0]  sync1_q;
    logic [4:0]  sync2_q;

    always_ff @(posedge clk_sys) begin
        sync1_q <= {serialIn, ~dcdIn_n, ~riIn_n, ~dsrIn_n, ~ctsIn_n};
        sync2_q <= sync1_q;
    end

    // ======================================================================
    // decode
    wire dlab     = lfc_q[`ULC_LFC_DLAB];
    wire loopback = mcr_q[`ULC_MCR_LOOP];
    wire selData  = (regAddr == `ULC_OFF_DATA);
    wire selIen   = (regAddr == `ULC_OFF_IEN);
    wire wrLfc    = regWr && (regAddr == `ULC_OFF_LFC);
    wire wrMcr    = regWr && (regAddr == `ULC_OFF_MCR);
    wire wrScr    = regWr && (regAddr == `ULC_OFF_SCR);
    wire wrDivLo  = regWr && selData && dlab;
    wire wrDivHi  = regWr && selIen && dlab;
    wire wrThr    = regWr && selData && !dlab;
    wire wrIen    = regWr && selIen && !dlab;
    wire rdRbr    = regRd && selData && !dlab;
    wire rdLsr    = regRd && (regAddr == `ULC_OFF_LSR);
    wire rdMsr    = regRd && (regAddr == `ULC_OFF_MSR);

    // loopback feeds modem outputs into status inputs
    wire [3:0] msNow = loopback ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} : sync2_q[3:0];

    // ======================================================================
    // baud generator
    logic [15:0] baud_q;
    logic        tick_q;
    // 16x tick, zero divisor held as one
    always_ff @(posedge clk_sys) begin
        if (sys_rst || wrDivLo || wrDivHi) begin
            baud_q <= 16'h0001;
            tick_q <= 1'b0;
        end else if (baud_q >= div_q) begin
            baud_q <= 16'h0001;
            tick_q <= 1'b1;
        end else begin
            baud_q <= baud_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // ======================================================================
    // transmitter
    ulc_pkg::ulc_ph_t txPh_q;
    logic [3:0] txOvs_q;
    logic [2:0] txBit_q;
    logic [7:0] txShift_q;
    logic       txPar_q;
    logic [1:0] txStopHalf_q;
    logic       txLine_q;

    wire [1:0] wordLen  = lfc_q[1:0];
    wire       parEn    = lfc_q[`ULC_LFC_PEN];
    wire       parFix   = lfc_q[`ULC_LFC_FIXP];
    wire       parEven  = lfc_q[`ULC_LFC_EVEN];
    wire       txEnd    = tick_q && (txOvs_q == `ULC_OVS_LAST);
    wire       txHalf   = tick_q && (txOvs_q == `ULC_OVS_HALF);
    wire       txParBit = parFix ? ~parEven : (txPar_q ^ ~parEven);
    // one stop; 1.5 for five bits; two otherwise
    wire [1:0] stopHalves = !lfc_q[`ULC_LFC_STOP] ? 2'd2 : (wordLen == 2'b00) ? 2'd3 : 2'd0;
    wire       txIdle   = (txPh_q == ulc_pkg::ULC_IDLE);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txPh_q       <= ulc_pkg::ULC_IDLE;
            txOvs_q      <= 4'h0;
            txBit_q      <= 3'h0;
            txShift_q    <= 8'h00;
            txPar_q      <= 1'b0;
            txStopHalf_q <= 2'd0;
            txLine_q     <= 1'b1;
        end else begin
            if (tick_q) begin
                txOvs_q <= txOvs_q + 4'h1;
            end
            case (txPh_q)
                ulc_pkg::ULC_IDLE: begin
                    txLine_q <= 1'b1;
                    if (thrFull_q && tick_q) begin
                        txPh_q    <= ulc_pkg::ULC_START;
                        txShift_q <= thr_q;
                        txPar_q   <= ^(thr_q & (8'hFF >> (2'd3 - wordLen)));
                        txOvs_q   <= 4'h0; // full sixteen-tick start bit
                        txLine_q  <= 1'b0;
                    end
                end
                ulc_pkg::ULC_START: begin
                    if (txEnd) begin
                        txPh_q   <= ulc_pkg::ULC_DATA;
                        txBit_q  <= 3'h0;
                        txLine_q <= txShift_q[0];
                    end
                end
                ulc_pkg::ULC_DATA: begin
                    if (txEnd) begin
                        txShift_q <= {1'b0, txShift_q[7:1]};
                        txBit_q   <= txBit_q + 3'h1;
                        txLine_q  <= txShift_q[1];
                        if (txBit_q == {1'b1, wordLen}) begin
                            txPh_q   <= parEn ? ulc_pkg::ULC_PAR : ulc_pkg::ULC_STOP;
                            txLine_q <= parEn ? txParBit : 1'b1;
                            txStopHalf_q <= stopHalves;
                        end
                    end
                end
                ulc_pkg::ULC_PAR: begin
                    if (txEnd) begin
                        txPh_q   <= ulc_pkg::ULC_STOP;
                        txLine_q <= 1'b1;
                    end
                end
                ulc_pkg::ULC_STOP: begin
                    // half bit steps count stop length; 0 stands for four
                    if (txEnd || txHalf) begin
                        txStopHalf_q <= txStopHalf_q - 2'd1;
                        if (txStopHalf_q == 2'd1) begin
                            txPh_q <= ulc_pkg::ULC_IDLE;
                        end
                    end
                end
                default: txPh_q <= ulc_pkg::ULC_IDLE;
            endcase
        end
    end

    // ======================================================================
    // receiver
    logic [7:0] rxData;
    logic       rxDone;
    logic       rxParityErr;
    logic       rxStopErr;
    logic       rxBreak;
    // loopback takes the internal line; the pin itself is held high
    wire        rxLine = loopback ? txLine_q : sync2_q[4];

    ulc_rx u_rx (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .tick16      (tick_q),
        .serialIn    (rxLine),
        .wordLen     (wordLen),
        .parityEn    (parEn),
        .parityFix   (parFix),
        .parityEven  (parEven),
        .rxData      (rxData),
        .rxDone      (rxDone),
        .rxParityErr (rxParityErr),
        .rxStopErr   (rxStopErr),
        .rxBreak     (rxBreak)
    );

    // ======================================================================
    // register writes; hardware set wins over read clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lfc_q     <= 8'h00;
            ien_q     <= 8'h00;
            mcr_q     <= 5'h00;
            scr_q     <= 8'h00;
            div_q     <= `ULC_DIV_RESET;
            thr_q     <= 8'h00;
            thrFull_q <= 1'b0;
            rbr_q     <= 8'h00;
            rdr_q     <= 1'b0;
            oer_q     <= 1'b0;
            per_q     <= 1'b0;
            ser_q     <= 1'b0;
            brk_q     <= 1'b0;
            msDelta_q <= 4'h0;
            msPrev_q  <= 4'h0;
        end else begin
            if (wrLfc) lfc_q <= regWrData;
            if (wrMcr) mcr_q <= regWrData[4:0];
            if (wrScr) scr_q <= regWrData;
            if (wrDivLo) div_q[7:0] <= regWrData;
            if (wrDivHi) div_q[15:8] <= regWrData;
            if (wrIen) ien_q <= {4'h0, regWrData[3:0]};
            if (wrThr) begin
                thr_q     <= regWrData;
                thrFull_q <= 1'b1;
            end else if (txIdle && thrFull_q && tick_q) begin
                thrFull_q <= 1'b0;
            end
            if (rdRbr) rdr_q <= 1'b0;
            if (rdLsr) begin
                oer_q <= 1'b0;
                per_q <= 1'b0;
                ser_q <= 1'b0;
                brk_q <= 1'b0;
            end
            if (rxDone) begin
                rbr_q <= rxData;
                rdr_q <= 1'b1;
                oer_q <= rdr_q && !rdRbr;
                per_q <= rxParityErr;
                ser_q <= rxStopErr;
                brk_q <= rxBreak;
            end
            // delta bits: changes, ring only on trailing edge
            msPrev_q <= msNow;
            if (rdMsr) msDelta_q <= 4'h0;
            msDelta_q <= (rdMsr ? 4'h0 : msDelta_q) |
                         {msNow[3] ^ msPrev_q[3], msPrev_q[2] & ~msNow[2],
                          msNow[1] ^ msPrev_q[1], msNow[0] ^ msPrev_q[0]};
        end
    end

    // ======================================================================
    // status, interrupt identification and read mux
    wire       thrEmpty = !thrFull_q;
    wire       tsrEmpty = thrEmpty && txIdle;
    wire [7:0] lsrVal = {1'b0, tsrEmpty, thrEmpty, brk_q, ser_q, per_q, oer_q, rdr_q};
    wire       intLs  = ien_q[`ULC_IEN_LS] && (oer_q || per_q || ser_q || brk_q);
    wire       intRx  = ien_q[`ULC_IEN_RX] && rdr_q;
    wire       intTx  = ien_q[`ULC_IEN_TX] && thrEmpty;
    wire       intMs  = ien_q[`ULC_IEN_MS] && (msDelta_q != 4'h0);
    // fifo bits and timeout read zero
    wire [7:0] iidVal = intLs ? `ULC_IID_LS : intRx ? `ULC_IID_RX :
                        intTx ? `ULC_IID_TX : intMs ? `ULC_IID_MS : `ULC_IID_NONE;
    wire [7:0] rdMux =
        (regAddr == `ULC_OFF_DATA) ? (dlab ? div_q[7:0] : rbr_q) :
        (regAddr == `ULC_OFF_IEN)  ? (dlab ? div_q[15:8] : ien_q) :
        (regAddr == `ULC_OFF_IID)  ? iidVal :
        (regAddr == `ULC_OFF_LFC)  ? lfc_q :
        (regAddr == `ULC_OFF_MCR)  ? {3'h0, mcr_q} :
        (regAddr == `ULC_OFF_LSR)  ? lsrVal :
        (regAddr == `ULC_OFF_MSR)  ? {msNow, msDelta_q} : scr_q;

    // read data registered, valid one cycle after strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) regRdData <= 8'h00;
        else if (regRd) regRdData <= rdMux;
    end

    // ======================================================================
    // pins; loopback holds line high and modem outputs inactive
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            serial_out      <= 1'b1;
            infrared_tx_out <= 1'b1;
            rtsOut_n        <= 1'b1;
            dtrOut_n        <= 1'b1;
            irq             <= 1'b0;
        end else begin
            serial_out      <= loopback ? 1'b1 : txLine_q;
            infrared_tx_out <= lfc_q[`ULC_LFC_SIL] ? 1'b0 : txLine_q;
            rtsOut_n        <= loopback | ~mcr_q[1];
            dtrOut_n        <= loopback | ~mcr_q[0];
            irq             <= mcr_q[`ULC_MCR_OUT2] && !loopback && (iidVal[0] == 1'b0);
        end
    end
endmodule

// ---- dv/ulc_uart_sva.sv ----
// assertion checker for the serial port register window and line outputs
`timescale 1ns/1ns
module ulc_uart_sva (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    input wire logic       serial_out,
    input wire logic       infrared_tx_out,
    input wire logic       irq
);
    logic [7:0]  lfc_q;
    logic [3:0]  ien_q;
    logic        irqEn_q;
    logic [15:0] div_q;

    // ============
    // shadow registers; banking follows the latch bit as the host sees it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            lfc_q   <= 8'h00;
            ien_q   <= 4'h0;
            irqEn_q <= 1'b0;
            div_q   <= 16'h0001;
        end else if (regWr) begin
            if (regAddr == 3'h3) lfc_q <= regWrData;
            if (regAddr == 3'h4) irqEn_q <= regWrData[3];
            if (regAddr == 3'h1 && !lfc_q[7]) ien_q <= regWrData[3:0];
            if (regAddr == 3'h0 && lfc_q[7]) div_q[7:0] <= regWrData;
            if (regAddr == 3'h1 && lfc_q[7]) div_q[15:8] <= regWrData;
        end
    end

    // ============
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    // a start bit lasts at least sixteen clocks even at divisor one
    sequence sLowBit;
        !serial_out [*8] ##1 !serial_out [*8];
    endsequence

    a_div_low: assert property (
        regRd && regAddr == 3'h0 && lfc_q[7] |=> regRdData == div_q[7:0])
        else $error("divisor low byte misread");
    a_div_high: assert property (
        regRd && regAddr == 3'h1 && lfc_q[7] |=> regRdData == div_q[15:8])
        else $error("divisor high byte misread");
    a_ien_read: assert property (
        regRd && regAddr == 3'h1 && !lfc_q[7] |=> regRdData == {4'h0, ien_q})
        else $error("interrupt enable misread");
    a_iid_fifo_zero: assert property (
        regRd && regAddr == 3'h2 |=> regRdData[7:6] == 2'h0 && !regRdData[3])
        else $error("fifo indicators not zero");
    a_status_err_zero: assert property (
        regRd && regAddr == 3'h5 |=> !regRdData[7])
        else $error("fifo error flag not zero");
    a_silence_low: assert property (
        lfc_q[6] && $stable(lfc_q[6]) |-> !infrared_tx_out)
        else $error("infrared output not silenced");
    a_start_width: assert property (
        $fell(serial_out) |-> sLowBit)
        else $error("start bit too short");
    a_irq_gated: assert property (
        !irqEn_q && !$past(irqEn_q) |-> !irq)
        else $error("interrupt raised while gated");
endmodule

bind ulc_uart ulc_uart_sva chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .serial_out(serial_out),
    .infrared_tx_out(infrared_tx_out), .irq(irq)
);

// ---- dv/ulc_peer.sv ----
// remote serial peer: sends characters and samples the transmit line
`timescale 1ns/1ns
module ulc_peer (
    input wire logic clk_sys,
    input wire logic serial_out,
    output logic     serialIn
);
    // idle mark, as a pulled-up line would rest
    initial serialIn = 1'b1;

    // ============
    // sender; par below zero means no parity bit
    // start, data lsb first, parity, stop
    task automatic send(input logic [7:0] d, input int nb, input int par, input int bt);
        @(posedge clk_sys);
        serialIn <= 1'b0;
        repeat (bt) @(posedge clk_sys);
        for (int i = 0; i < nb + (par >= 0); i++) begin
            serialIn <= (i < nb) ? d[i] : par[0];
            repeat (bt) @(posedge clk_sys);
        end
        serialIn <= 1'b1;
        repeat (bt) @(posedge clk_sys);
    endtask

    // ============
    // sampler; gap counts clocks from the first stop sample to the next start
    // align on the falling start edge
    task automatic grab(input int n, input int bt, output logic [11:0] bits, output int gap);
        int k;
        bits = 12'h000;
        gap = 0;
        k = 0;
        while (serial_out !== 1'b0 && k < 4000) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (bt / 2) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            repeat (bt) @(posedge clk_sys);
            bits[i] = serial_out;
        end
        while (serial_out !== 1'b0 && gap < 4 * bt) begin
            @(posedge clk_sys);
            gap++;
        end
    endtask
endmodule

// ---- dv/ulc_tb.sv ----
// testbench: register window, transmit formats, receive and interrupts
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, a, b); end end
module tb;
    logic        clk_sys;
    logic        sys_rst;
    logic [2:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdData;
    logic        serialIn;
    logic        serial_out;
    logic        infrared_tx_out;
    logic        irq;
    logic [7:0]  v;
    logic [11:0] bits;
    int          gap;
    int          error_cnt;
    int          checked;

    // modem inputs held inactive; only the lines, irq and registers are exercised
    ulc_uart dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .serialIn(serialIn), .serial_out(serial_out), .infrared_tx_out(infrared_tx_out),
        .ctsIn_n(1'b1), .dsrIn_n(1'b1), .riIn_n(1'b1), .dcdIn_n(1'b1),
        .rtsOut_n(), .dtrOut_n(), .irq(irq));
    ulc_peer peer (.clk_sys(clk_sys), .serial_out(serial_out), .serialIn(serialIn));

    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ============
    // host bus cycles; a gap cycle follows every strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // latch set, divisor bytes, latch cleared
    task automatic set_fmt(input logic [7:0] lfc, input logic [7:0] div);
        wr(3'h3, 8'h80);
        wr(3'h0, div);
        wr(3'h1, 8'h00);
        wr(3'h3, lfc);
    endtask
    // two characters back to back; the second one bounds the stop length
    task automatic frame(input logic [7:0] lfc, input int div, input logic [7:0] d,
                         input int n, input logic [11:0] exp, input int hs);
        int k;
        int bt;
        int e;
        bt = 16 * div;
        e = hs * bt / 2 - bt / 2;
        set_fmt(lfc, div[7:0]);
        fork
            peer.grab(n, bt, bits, gap);
            begin
                wr(3'h0, d);
                v = 8'h00;
                for (k = 0; k < 300 && !v[5]; k++) rd(3'h5, v);
                wr(3'h0, d);
            end
        join
        `CHK(bits, exp)
        `CHK(gap >= e - 1 && gap <= e + 3 * div + 2, 1'b1)
        tick(13 * bt);
    endtask

    // ============
    // scenarios
    task automatic t_regs();
        rd(3'h3, v);
        `CHK(v, 8'h00)
        wr(3'h3, 8'h80);
        rd(3'h0, v);
        `CHK(v, 8'h01)
        wr(3'h0, 8'h5A);
        wr(3'h1, 8'hC3);
        rd(3'h1, v);
        `CHK(v, 8'hC3)
        rd(3'h0, v);
        `CHK(v, 8'h5A)
        wr(3'h3, 8'h03);
        rd(3'h1, v);
        `CHK(v, 8'h00)
        wr(3'h1, 8'hFF);
        rd(3'h1, v);
        `CHK(v, 8'h0F)
        wr(3'h1, 8'h00);
        rd(3'h0, v);
        `CHK(v, 8'h00)
        wr(3'h2, 8'hC1);
        rd(3'h2, v);
        `CHK(v, 8'h01)
        rd(3'h5, v);
        `CHK(v[7], 1'b0)
        $display("t_regs done");
    endtask
    task automatic t_formats();
        frame(8'h00, 1, 8'h15, 6, 12'h035, 2);
        frame(8'h19, 1, 8'h2D, 8, 12'h0AD, 2);
        frame(8'h0A, 1, 8'h55, 9, 12'h1D5, 2);
        frame(8'h3B, 1, 8'hFF, 10, 12'h2FF, 2);
        frame(8'h2F, 1, 8'h00, 10, 12'h300, 4);
        frame(8'h13, 1, 8'h01, 9, 12'h101, 2);
        frame(8'h04, 1, 8'h1F, 6, 12'h03F, 3);
        frame(8'h06, 3, 8'h4B, 8, 12'h0CB, 4);
        $display("t_formats done");
    endtask
    task automatic t_rx_irq();
        set_fmt(8'h1B, 8'h01);
        wr(3'h4, 8'h08);
        wr(3'h1, 8'h01);
        peer.send(8'hC1, 8, 1, 16);
        tick(4);
        `CHK(irq, 1'b1)
        rd(3'h2, v);
        `CHK(v, 8'h04)
        rd(3'h0, v);
        `CHK(v, 8'hC1)
        tick(2);
        `CHK(irq, 1'b0)
        wr(3'h1, 8'h00);
        peer.send(8'h3C, 8, 1, 16);
        tick(4);
        `CHK(irq, 1'b0)
        rd(3'h5, v);
        `CHK(v[2:0], 3'b101)
        rd(3'h5, v);
        `CHK(v[2], 1'b0)
        wr(3'h1, 8'h04);
        peer.send(8'h5A, 8, 0, 16);
        tick(4);
        `CHK(irq, 1'b1)
        rd(3'h2, v);
        `CHK(v, 8'h06)
        rd(3'h5, v);
        `CHK(v[2:0], 3'b011)
        rd(3'h0, v);
        `CHK(v, 8'h5A)
        tick(2);
        `CHK(irq, 1'b0)
        $display("t_rx_irq done");
    endtask
    task automatic t_silence();
        set_fmt(8'h40, 8'h01);
        fork
            peer.grab(6, 16, bits, gap);
            wr(3'h0, 8'h0A);
        join
        `CHK(bits[5:0], 6'h2A)
        `CHK(infrared_tx_out, 1'b0)
        wr(3'h3, 8'h00);
        tick(3);
        `CHK(infrared_tx_out, 1'b1)
        wr(3'h4, 8'h10);
        wr(3'h0, 8'h16);
        tick(160);
        rd(3'h0, v);
        `CHK(v, 8'h16)
        $display("t_silence done");
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard: the full run needs well under 20000 clocks
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end

    // main sequence after 12 reset clocks
    initial begin
        sys_rst = 1'b1;
        regAddr = 3'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        error_cnt = 0;
        checked = 0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_formats();
        t_rx_irq();
        t_silence();
        end_sim();
    end
endmodule
